// ===== logic/sdram_controller_end.sv
module sdram_req_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   input wire logic clk_en,
   // Fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // Drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int PTR_W = $clog2(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [PTR_W-1:0] wr;
      logic [PTR_W-1:0] rd;
      logic [PTR_W:0] count;
      logic ready;
      logic valid;
   } fifo_state_t;

   fifo_state_t s;
   fifo_state_t next_s;
   logic push;
   logic pop;

   assign push = in_valid && s.ready;
   assign pop = out_ready && s.valid;

   always_comb begin
      next_s = s;
      if (push) begin
         next_s.mem[s.wr] = in_data;
         next_s.wr = PTR_W'((s.wr + 1'b1) % DEPTH);
      end
      if (pop) begin
         next_s.rd = PTR_W'((s.rd + 1'b1) % DEPTH);
      end
      next_s.count = s.count + (PTR_W+1)'(push) - (PTR_W+1)'(pop);
      next_s.ready = next_s.count != (PTR_W+1)'(DEPTH);
      next_s.valid = next_s.count != '0;
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         s <= '0;
         s.ready <= 1'b1;
      end else if (clk_en) begin
         s <= next_s;
      end
   end

   assign in_ready = s.ready;
   assign out_valid = s.valid;
   assign out_data = s.mem[s.rd];
endmodule // sdram_req_fifo

module sdram_controller_end #(
   parameter logic [sdram_pkg::ADDR_W-1:0] MODE_VALUE =
      sdram_pkg::MODE_DEFAULT,
   parameter int DEPTH = sdram_pkg::FIFO_DEPTH
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   input wire logic clk_en,
   // Memory pins
   sdram_if.ctl bus,
   // Requests
   input wire logic req_valid,
   output logic req_ready,
   input wire logic req_write,
   input wire logic [sdram_pkg::BANK_W-1:0] req_bank,
   input wire logic [sdram_pkg::ADDR_W-1:0] req_row,
   input wire logic [sdram_pkg::COL_W-1:0] req_col,
   input wire logic [sdram_pkg::NUM_BYTES-1:0] req_mask,
   input wire logic [sdram_pkg::DATA_W-1:0] req_data,
   // Read answers
   output logic rsp_valid,
   output logic [sdram_pkg::DATA_W-1:0] rsp_data,
   // Power and status
   input wire logic sleep_req,
   output logic init_done
);
   typedef struct packed {
      logic write;
      logic [sdram_pkg::BANK_W-1:0] bank;
      logic [sdram_pkg::ADDR_W-1:0] row;
      logic [sdram_pkg::COL_W-1:0] col;
      logic [sdram_pkg::NUM_BYTES-1:0] mask;
      logic [sdram_pkg::DATA_W-1:0] data;
   } req_t;

   typedef struct packed {
      sdram_pkg::ctl_state_t state;
      logic cs_n;
      logic [2:0] cmd;
      logic [sdram_pkg::ADDR_W-1:0] addr;
      logic [sdram_pkg::BANK_W-1:0] bank;
      logic [sdram_pkg::NUM_BYTES-1:0] mask;
      logic cke;
      logic [sdram_pkg::DATA_W-1:0] dq;
      logic dq_oe;
      logic [sdram_pkg::NUM_BANKS-1:0] open;
      logic [sdram_pkg::NUM_BANKS-1:0][sdram_pkg::ADDR_W-1:0] open_row;
      req_t cur;
      logic [2:0] rd_sh;
      logic rsp_valid;
      logic [sdram_pkg::DATA_W-1:0] rsp_data;
      logic init_done;
   } ctl_reg_t;

   ctl_reg_t s;
   ctl_reg_t next_s;
   req_t in_req;
   req_t head;
   logic head_valid;
   logic pop;

   assign in_req = '{req_write, req_bank, req_row, req_col, req_mask,
                     req_data};

   // Queue stalls the requester only once DEPTH requests are waiting
   sdram_req_fifo #(.WIDTH($bits(req_t)), .DEPTH(DEPTH)) u_fifo (
      .clk(clk),
      .rst_n(rst_n),
      .clk_en(clk_en),
      .in_valid(req_valid),
      .in_ready(req_ready),
      .in_data(in_req),
      .out_valid(head_valid),
      .out_ready(pop),
      .out_data(head)
   );

   // ------------------------------------------------------------------
   // Command sequencing
   // ------------------------------------------------------------------
   always_comb begin
      next_s = s;
      pop = 1'b0;
      next_s.cs_n = 1'b1;
      next_s.cmd = sdram_pkg::CMD_NOP;
      next_s.dq_oe = 1'b0;
      next_s.mask = '0;
      next_s.rsp_valid = 1'b0;
      next_s.rd_sh = {s.rd_sh[1:0], 1'b0};
      if (s.rd_sh[2]) begin
         // Third edge after the read leaves: the beat is on the bus
         next_s.rsp_valid = 1'b1; // R7
         next_s.rsp_data = bus.data_lines;
      end
      unique case (s.state)
         sdram_pkg::ST_INIT_PRE: begin
            next_s.cs_n = 1'b0;
            next_s.cmd = sdram_pkg::CMD_PRECHARGE;
            next_s.addr = sdram_pkg::PRE_ALL_ADDR; // R15
            next_s.open = '0;
            next_s.state = sdram_pkg::ST_INIT_MRS;
         end
         sdram_pkg::ST_INIT_MRS: begin
            next_s.cs_n = 1'b0;
            next_s.cmd = sdram_pkg::CMD_MRS; // R12
            next_s.addr = MODE_VALUE;
            next_s.init_done = 1'b1;
            next_s.state = sdram_pkg::ST_IDLE;
         end
         sdram_pkg::ST_IDLE: begin
            // No new access while a read beat still owns the bus
            if (sleep_req && s.rd_sh == 3'h0) begin
               next_s.cke = 1'b0; // R9
               next_s.state = sdram_pkg::ST_SLEEP;
            end else if (head_valid && s.rd_sh == 3'h0) begin // R10
               pop = 1'b1;
               next_s.cur = head;
               next_s.state = sdram_pkg::ST_OPEN;
            end
         end
         sdram_pkg::ST_OPEN: begin
            next_s.cs_n = 1'b0;
            next_s.bank = s.cur.bank; // R4
            if (s.open[s.cur.bank] &&
                s.open_row[s.cur.bank] == s.cur.row) begin
               next_s.addr = {4'h0, s.cur.col}; // R2
               next_s.mask = s.cur.mask; // R11
               if (s.cur.write) begin
                  next_s.cmd = sdram_pkg::CMD_WRITE; // R14
                  next_s.dq = s.cur.data;
                  next_s.dq_oe = 1'b1; // R10
               end else begin
                  next_s.cmd = sdram_pkg::CMD_READ; // R13
                  next_s.rd_sh = 3'h1;
               end
               next_s.state = sdram_pkg::ST_IDLE;
            end else if (s.open[s.cur.bank]) begin
               next_s.cmd = sdram_pkg::CMD_PRECHARGE;
               next_s.addr = '0; // R3
               next_s.open[s.cur.bank] = 1'b0;
            end else begin
               next_s.cmd = sdram_pkg::CMD_ACTIVATE;
               next_s.addr = s.cur.row; // R2
               next_s.open[s.cur.bank] = 1'b1;
               next_s.open_row[s.cur.bank] = s.cur.row;
            end
         end
         sdram_pkg::ST_SLEEP: begin
            if (!sleep_req) begin
               next_s.cke = 1'b1;
               next_s.state = sdram_pkg::ST_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         s <= '0;
         s.state <= sdram_pkg::ST_INIT_PRE;
         s.cs_n <= 1'b1;
         s.cmd <= sdram_pkg::CMD_NOP;
         s.cke <= 1'b1;
      end else if (clk_en) begin
         s <= next_s;
      end
   end

   // Every pin leaves a flop so it is stable at the sampling edge
   assign bus.cs_n = s.cs_n; // R1
   assign {bus.ras_n, bus.cas_n, bus.we_n} = s.cmd;
   assign bus.multiplexed_address = s.addr;
   assign bus.bank_select = s.bank;
   assign {bus.upper_byte_mask, bus.lower_byte_mask} = s.mask;
   assign bus.clock_gate = s.cke;
   assign bus.ctl_dq = s.dq;
   assign bus.ctl_dq_oe = s.dq_oe;
   assign rsp_valid = s.rsp_valid;
   assign rsp_data = s.rsp_data;
   assign init_done = s.init_done;
endmodule // sdram_controller_end

// ===== logic/sdram_device_end.sv
module sdram_device_end (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   input wire logic clk_en,
   // Memory pins
   sdram_if.dev bus,
   // Status
   output logic [sdram_pkg::ADDR_W-1:0] mode_value,
   output logic [sdram_pkg::NUM_BANKS-1:0] banks_active,
   output sdram_pkg::power_t power_mode
);
   localparam int IDX_W = sdram_pkg::BANK_W + sdram_pkg::ROW_KEEP +
                          sdram_pkg::COL_W;
   localparam int WORDS = 1 << IDX_W;

   typedef struct packed {
      sdram_pkg::power_t pwr;
      logic [sdram_pkg::ADDR_W-1:0] mode;
      logic [sdram_pkg::NUM_BANKS-1:0] active;
      logic [sdram_pkg::NUM_BANKS-1:0][sdram_pkg::ADDR_W-1:0] row;
      logic [2:0] b_left;
      logic [2:0] b_idx;
      logic [sdram_pkg::COL_W-1:0] b_start;
      logic [sdram_pkg::BANK_W-1:0] b_bank;
      logic b_wr;
      logic rd_pend;
      logic [sdram_pkg::NUM_BYTES-1:0] mask_q;
      logic [sdram_pkg::DATA_W-1:0] rd_q;
      logic [sdram_pkg::DATA_W-1:0] dq_out;
      logic [sdram_pkg::NUM_BYTES-1:0] dq_oe;
      logic [WORDS-1:0][sdram_pkg::DATA_W-1:0] mem;
   } dev_state_t;

   dev_state_t s;
   dev_state_t next_s;
   logic [2:0] cmd;
   logic take;
   logic [sdram_pkg::NUM_BYTES-1:0] mask_in;
   logic [3:0] burst_len;
   logic [sdram_pkg::COL_W-1:0] wrap_mask;
   logic acc_en;
   logic acc_wr;
   logic [sdram_pkg::BANK_W-1:0] acc_bank;
   logic [sdram_pkg::COL_W-1:0] acc_col;
   logic [IDX_W-1:0] idx;

   // ------------------------------------------------------------------
   // Pin decode
   // ------------------------------------------------------------------
   assign cmd = {bus.ras_n, bus.cas_n, bus.we_n}; // R6
   assign take = !bus.cs_n && bus.clock_gate; // R5 R16
   assign mask_in = {bus.upper_byte_mask, bus.lower_byte_mask}; // R11

   always_comb begin
      unique case (s.mode[sdram_pkg::BL_LSB +: 3])
         3'h1: burst_len = 4'h2;
         3'h2: burst_len = 4'h4;
         3'h3: burst_len = 4'h8;
         // Full page and reserved codes fall back to single beats
         default: burst_len = 4'h1;
      endcase
      wrap_mask = 8'(burst_len - 4'h1);
   end

   function automatic logic [sdram_pkg::COL_W-1:0] burst_col(
      input logic [sdram_pkg::COL_W-1:0] start,
      input logic [2:0] beat,
      input logic [sdram_pkg::COL_W-1:0] wmask,
      input logic inter
   );
      logic [sdram_pkg::COL_W-1:0] step;
      step = {5'h00, beat};
      if (inter) begin
         burst_col = start ^ (step & wmask);
      end else begin
         burst_col = (start & ~wmask) | (8'(start + step) & wmask);
      end
   endfunction

   // ------------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------------
   always_comb begin
      next_s = s;
      acc_en = 1'b0;
      acc_wr = 1'b0;
      acc_bank = s.b_bank;
      acc_col = s.b_start;
      if (!bus.clock_gate) begin // R9
         // Internal clock frozen: pipelines and bursts hold
         if (s.pwr == sdram_pkg::PWR_RUN) begin
            if (!bus.cs_n && cmd == sdram_pkg::CMD_REFRESH) begin
               next_s.pwr = sdram_pkg::PWR_SELF_REFRESH;
            end else if (|s.active || s.b_left != 3'h0 || s.rd_pend) begin
               next_s.pwr = sdram_pkg::PWR_SUSPEND;
            end else begin
               next_s.pwr = sdram_pkg::PWR_DOWN;
            end
         end
      end else begin
         next_s.pwr = sdram_pkg::PWR_RUN;
         // Mask taken with the read edge gates the beat two edges on
         next_s.mask_q = mask_in; // R1
         next_s.dq_out = s.rd_q;
         next_s.dq_oe = {2{s.rd_pend}} & ~s.mask_q; // R7 R10
         next_s.rd_pend = 1'b0;
         if (s.b_left != 3'h0) begin
            acc_en = 1'b1;
            acc_wr = s.b_wr;
            acc_col = burst_col(s.b_start, s.b_idx, wrap_mask,
                                s.mode[sdram_pkg::INTERLEAVE_BIT]);
            next_s.b_left = s.b_left - 3'h1;
            next_s.b_idx = s.b_idx + 3'h1;
         end
         if (take) begin
            unique case (cmd) // R6
               sdram_pkg::CMD_MRS: begin
                  next_s.mode = bus.multiplexed_address; // R12
               end
               sdram_pkg::CMD_ACTIVATE: begin
                  next_s.active[bus.bank_select] = 1'b1; // R4
                  next_s.row[bus.bank_select] = bus.multiplexed_address; // R2
               end
               sdram_pkg::CMD_PRECHARGE: begin
                  if (bus.multiplexed_address[sdram_pkg::PRE_ALL_BIT]) begin
                     next_s.active = '0; // R3 R15
                     next_s.b_left = 3'h0;
                  end else begin
                     next_s.active[bus.bank_select] = 1'b0; // R15
                     if (bus.bank_select == s.b_bank) begin
                        next_s.b_left = 3'h0;
                     end
                  end
               end
               sdram_pkg::CMD_READ, sdram_pkg::CMD_WRITE: begin
                  // A new access overrides the rest of a running burst
                  if (s.active[bus.bank_select]) begin
                     acc_en = 1'b1;
                     acc_wr = (cmd == sdram_pkg::CMD_WRITE); // R13 R14
                     acc_bank = bus.bank_select; // R4
                     acc_col = bus.multiplexed_address[sdram_pkg::COL_W-1:0];
                     next_s.b_start = acc_col; // R2
                     next_s.b_bank = bus.bank_select;
                     next_s.b_wr = acc_wr;
                     next_s.b_idx = 3'h1;
                     next_s.b_left = 3'(burst_len - 4'h1);
                  end
               end
               sdram_pkg::CMD_STOP: begin
                  acc_en = 1'b0;
                  next_s.b_left = 3'h0;
               end
               sdram_pkg::CMD_REFRESH, sdram_pkg::CMD_NOP: begin
               end
            endcase
         end
      end
      idx = {acc_bank, s.row[acc_bank][sdram_pkg::ROW_KEEP-1:0], acc_col};
      if (acc_en) begin
         if (acc_wr) begin
            for (int b = 0; b < sdram_pkg::NUM_BYTES; b++) begin
               if (!mask_in[b]) begin // R8
                  next_s.mem[idx][b*sdram_pkg::BYTE_W +: sdram_pkg::BYTE_W] =
                     bus.data_lines[b*sdram_pkg::BYTE_W +: sdram_pkg::BYTE_W];
               end
            end
         end else begin
            next_s.rd_q = s.mem[idx];
            next_s.rd_pend = 1'b1;
         end
      end
   end

   // ------------------------------------------------------------------
   // State register
   // ------------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         s <= '0;
         s.pwr <= sdram_pkg::PWR_RUN;
         s.mode <= sdram_pkg::MODE_RESET;
      end else if (clk_en) begin
         s <= next_s;
      end
   end

   assign bus.dev_dq = s.dq_out;
   assign bus.dev_dq_oe = s.dq_oe;
   assign mode_value = s.mode;
   assign banks_active = s.active;
   assign power_mode = s.pwr;
endmodule // sdram_device_end

// ===== shared/sdram_if.sv
interface sdram_if;
   logic cs_n;
   logic ras_n;
   logic cas_n;
   logic we_n;
   logic [sdram_pkg::ADDR_W-1:0] multiplexed_address;
   logic [sdram_pkg::BANK_W-1:0] bank_select;
   logic upper_byte_mask;
   logic lower_byte_mask;
   logic clock_gate;
   logic [sdram_pkg::DATA_W-1:0] ctl_dq;
   logic ctl_dq_oe;
   logic [sdram_pkg::DATA_W-1:0] dev_dq;
   logic [sdram_pkg::NUM_BYTES-1:0] dev_dq_oe;
   wire [sdram_pkg::DATA_W-1:0] data_lines;

   // Shared bus level worked out per byte from the two enables;
   // a lane nobody drives reads as zero, as if pulled down
   assign data_lines[15:8] = dev_dq_oe[1] ? dev_dq[15:8] :
                             ctl_dq_oe ? ctl_dq[15:8] : 8'h00;
   assign data_lines[7:0] = dev_dq_oe[0] ? dev_dq[7:0] :
                            ctl_dq_oe ? ctl_dq[7:0] : 8'h00;

   modport dev (
      input cs_n, ras_n, cas_n, we_n, multiplexed_address, bank_select,
      input upper_byte_mask, lower_byte_mask, clock_gate, data_lines,
      output dev_dq, dev_dq_oe
   );
   modport ctl (
      output cs_n, ras_n, cas_n, we_n, multiplexed_address, bank_select,
      output upper_byte_mask, lower_byte_mask, clock_gate,
      output ctl_dq, ctl_dq_oe,
      input data_lines
   );
endinterface

// ===== shared/sdram_pkg.sv
// Overview of operation
// R1 - All inputs sampled on rising clock edge
// R2 - Twelve row lines, low eight column lines
// R3 - Precharge checks the precharge-all line
// R4 - Bank select picks activated or accessed bank
// R5 - Deselected chip ignores commands, ops continue
// R6 - Strobe levels together decode the operation
// R7 - Read mask floats byte two cycles later
// R8 - Write mask blocks byte same edge
// R9 - Clock gate low: power-down, suspend, self-refresh
// R10 - Data lines driven by one side only
// R11 - Upper mask upper byte, lower mask lower
// R12 - All strobes low: mode register set
// R13 - Column strobe low alone: burst read
// R14 - Column and write strobes low: burst write
// R15 - Precharge-all high: every bank, else one
// R16 - Decode only when selected and clock enabled
package sdram_pkg;
   localparam int ADDR_W = 12;
   localparam int COL_W = 8;
   localparam int BANK_W = 2;
   localparam int NUM_BANKS = 4;
   localparam int DATA_W = 16;
   localparam int BYTE_W = 8;
   localparam int NUM_BYTES = 2;
   localparam int PRE_ALL_BIT = 10;
   // Row bits kept in the storage index; higher row bits alias
   localparam int ROW_KEEP = 1;
   localparam int FIFO_DEPTH = 16;
   localparam logic [ADDR_W-1:0] MODE_RESET = 12'h000;
   // Burst length 1, sequential, latency 2
   localparam logic [ADDR_W-1:0] MODE_DEFAULT = 12'h020;
   localparam logic [ADDR_W-1:0] PRE_ALL_ADDR = 12'h400;
   localparam int BL_LSB = 0;
   localparam int INTERLEAVE_BIT = 3;

   // Strobe code {row, column, write}, all active low
   localparam logic [2:0] CMD_MRS = 3'h0;
   localparam logic [2:0] CMD_REFRESH = 3'h1;
   localparam logic [2:0] CMD_PRECHARGE = 3'h2;
   localparam logic [2:0] CMD_ACTIVATE = 3'h3;
   localparam logic [2:0] CMD_WRITE = 3'h4;
   localparam logic [2:0] CMD_READ = 3'h5;
   localparam logic [2:0] CMD_STOP = 3'h6;
   localparam logic [2:0] CMD_NOP = 3'h7;

   typedef enum logic [3:0] {
      PWR_RUN = 4'h1,
      PWR_DOWN = 4'h2,
      PWR_SUSPEND = 4'h4,
      PWR_SELF_REFRESH = 4'h8
   } power_t;

   typedef enum logic [4:0] {
      ST_INIT_PRE = 5'h01,
      ST_INIT_MRS = 5'h02,
      ST_IDLE = 5'h04,
      ST_OPEN = 5'h08,
      ST_SLEEP = 5'h10
   } ctl_state_t;
endpackage

// ===== verification/sdram_pin_command_interface_sva.sv
module sdram_pin_command_interface_sva (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Command pins
   input wire logic cs_n,
   input wire logic ras_n,
   input wire logic cas_n,
   input wire logic we_n,
   input wire logic [sdram_pkg::ADDR_W-1:0] multiplexed_address,
   input wire logic upper_byte_mask,
   input wire logic lower_byte_mask,
   input wire logic clock_gate,
   // Data lanes
   input wire logic ctl_dq_oe,
   input wire logic [sdram_pkg::DATA_W-1:0] dev_dq,
   input wire logic [sdram_pkg::NUM_BYTES-1:0] dev_dq_oe
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   logic [2:0] code;
   logic sel;
   logic rd;
   logic [1:0] mask;
   assign code = {ras_n, cas_n, we_n};
   assign sel = !cs_n && clock_gate;
   assign rd = sel && code == sdram_pkg::CMD_READ;
   assign mask = {upper_byte_mask, lower_byte_mask};

   // -----------------------------------------------------------
   // Command sequences
   // -----------------------------------------------------------
   sequence read_s;
      rd;
   endsequence
   sequence write_s;
      sel && code == sdram_pkg::CMD_WRITE;
   endsequence
   sequence pre_all_s;
      sel && code == sdram_pkg::CMD_PRECHARGE &&
         multiplexed_address[sdram_pkg::PRE_ALL_BIT];
   endsequence
   sequence mrs_s;
      sel && code == sdram_pkg::CMD_MRS &&
         multiplexed_address == sdram_pkg::MODE_DEFAULT;
   endsequence

   // -----------------------------------------------------------
   // Checks
   // -----------------------------------------------------------
   read_float_a: assert property (
      read_s |-> ##2 dev_dq_oe == ~$past(mask, 2))
      else $error("read lane enable does not follow mask");
   read_window_a: assert property (
      dev_dq_oe != 2'h0 |-> $past(rd, 2))
      else $error("device drives data without a selected read");
   bus_excl_a: assert property (
      ctl_dq_oe |-> dev_dq_oe == 2'h0)
      else $error("both ends drive the data lines");
   write_data_a: assert property (
      write_s |-> ctl_dq_oe)
      else $error("write command without data on the same edge");
   init_seq_a: assert property (
      $rose(rst_n) |-> ##1 pre_all_s ##1 mrs_s)
      else $error("start-up precharge and mode set missing");
   read_quiet_a: assert property (
      read_s |-> ##1 !ctl_dq_oe [*2])
      else $error("controller drives data while read returns");
   gate_freeze_a: assert property (
      !clock_gate |=> $stable(dev_dq_oe) && $stable(dev_dq))
      else $error("data outputs move while clock is gated");
   deselect_keep_a: assert property (
      read_s ##1 (cs_n && clock_gate) |-> ##1
         dev_dq_oe == ~$past(mask, 2))
      else $error("read lost after deselect");
endmodule // sdram_pin_command_interface_sva

// ===== verification/sdram_pin_command_interface_tb.sv
module sdram_pin_command_interface_tb;
   timeunit 1ns;
   timeprecision 1ps;

   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic clk_en = 1'b1;
   logic req_valid = 1'b0;
   logic req_write = 1'b0;
   logic [1:0] req_bank = 2'h0;
   logic [11:0] req_row = 12'h000;
   logic [7:0] req_col = 8'h00;
   logic [1:0] req_mask = 2'h0;
   logic [15:0] req_data = 16'h0000;
   logic sleep_req = 1'b0;
   logic req_ready, rsp_valid, init_done;
   logic [15:0] rsp_data;
   logic [11:0] mode_value;
   logic [3:0] banks_active;
   sdram_pkg::power_t power_mode;
   int n_fail = 0;
   int num_checks = 0;
   int cycles = 0;
   logic saw_full;

   always #25 clk = ~clk;

   // -----------------------------------------------------------
   // Both ends and the pin checker
   // -----------------------------------------------------------
   sdram_if i_sdram_if ();
   sdram_device_end i_sdram_device_end (.clk(clk), .rst_n(rst_n),
      .clk_en(clk_en), .bus(i_sdram_if), .mode_value(mode_value),
      .banks_active(banks_active), .power_mode(power_mode));
   sdram_controller_end i_sdram_controller_end (.clk(clk),
      .rst_n(rst_n), .clk_en(clk_en), .bus(i_sdram_if),
      .req_valid(req_valid), .req_ready(req_ready),
      .req_write(req_write), .req_bank(req_bank), .req_row(req_row),
      .req_col(req_col), .req_mask(req_mask), .req_data(req_data),
      .rsp_valid(rsp_valid), .rsp_data(rsp_data),
      .sleep_req(sleep_req), .init_done(init_done));
   sdram_pin_command_interface_sva i_sva (.clk(clk), .rst_n(rst_n),
      .cs_n(i_sdram_if.cs_n), .ras_n(i_sdram_if.ras_n),
      .cas_n(i_sdram_if.cas_n), .we_n(i_sdram_if.we_n),
      .multiplexed_address(i_sdram_if.multiplexed_address),
      .upper_byte_mask(i_sdram_if.upper_byte_mask),
      .lower_byte_mask(i_sdram_if.lower_byte_mask),
      .clock_gate(i_sdram_if.clock_gate),
      .ctl_dq_oe(i_sdram_if.ctl_dq_oe), .dev_dq(i_sdram_if.dev_dq),
      .dev_dq_oe(i_sdram_if.dev_dq_oe));

   // -----------------------------------------------------------
   // Tasks
   // -----------------------------------------------------------
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   task automatic check(input logic [15:0] seen, input logic [15:0] exp,
         input string msg);
      num_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("wrong value at %0t: %s seen %h expected %h", $time,
            msg, seen, exp);
      end
   endtask

   // Called just after a falling edge; leaves valid high so that
   // requests can follow back to back
   task automatic push(input logic wr, input logic [1:0] b,
         input logic [11:0] row, input logic [7:0] col,
         input logic [1:0] m, input logic [15:0] d);
      int n;
      n = 0;
      req_valid = 1'b1;
      req_write = wr;
      req_bank = b;
      req_row = row;
      req_col = col;
      req_mask = m;
      req_data = d;
      while (req_ready !== 1'b1 && n < 100) begin
         @(negedge clk);
         n++;
      end
      if (n == 100) begin
         n_fail++;
      end
      @(negedge clk);
   endtask

   task automatic rd(input logic [1:0] b, input logic [11:0] row,
         input logic [7:0] col, input logic [1:0] m,
         input logic [15:0] exp, input logic [15:0] care);
      int n;
      n = 0;
      push(1'b0, b, row, col, m, 16'h0000);
      req_valid = 1'b0;
      while (rsp_valid !== 1'b1 && n < 60) begin
         @(negedge clk);
         n++;
      end
      check({15'h0000, rsp_valid}, 16'h0001, "read answer");
      check(rsp_data & care, exp & care, "read data");
   endtask

   task automatic wait_for(ref logic sig, input logic lvl);
      int n;
      n = 0;
      while (sig !== lvl && n < 100) begin
         @(negedge clk);
         n++;
      end
      check({15'h0000, sig}, {15'h0000, lvl}, "wait level");
   endtask

   task automatic do_reset();
      @(negedge clk);
      rst_n = 1'b0;
      repeat (4) @(negedge clk);
      rst_n = 1'b1;
      wait_for(init_done, 1'b1);
      // Done rises with the mode set on the pins; the device takes it
      // one edge later
      @(negedge clk);
      check({4'h0, mode_value}, 16'h0020, "mode after start-up");
      check({12'h000, banks_active}, 16'h0000, "banks closed");
      check({12'h000, power_mode}, 16'h0001, "power run");
   endtask

   always @(posedge clk) begin
      cycles++;
      if (cycles == 8000) begin
         n_fail++;
         end_of_test();
      end
   end

   // -----------------------------------------------------------
   // Scenarios
   // -----------------------------------------------------------
   initial begin
      do_reset();
      // Same row and column in every bank must stay apart
      for (int b = 0; b < 4; b++) begin
         push(1'b1, b[1:0], 12'h005, 8'h12, 2'b00, 16'hA5C0 + 16'(b));
      end
      for (int b = 0; b < 4; b++) begin
         rd(b[1:0], 12'h005, 8'h12, 2'b00, 16'hA5C0 + 16'(b), 16'hFFFF);
      end
      // Byte lanes masked independently on writes
      push(1'b1, 2'h1, 12'h005, 8'h12, 2'b10, 16'h1122);
      rd(2'h1, 12'h005, 8'h12, 2'b00, 16'hA522, 16'hFFFF);
      push(1'b1, 2'h1, 12'h005, 8'h12, 2'b01, 16'h3344);
      rd(2'h1, 12'h005, 8'h12, 2'b00, 16'h3322, 16'hFFFF);
      // Masked read lanes float; only the open lane is compared
      rd(2'h1, 12'h005, 8'h12, 2'b10, 16'h3322, 16'h00FF);
      rd(2'h1, 12'h005, 8'h12, 2'b01, 16'h3322, 16'hFF00);
      // Row miss in one bank, top column
      push(1'b1, 2'h2, 12'h007, 8'hFF, 2'b00, 16'h7777);
      rd(2'h2, 12'h005, 8'h12, 2'b00, 16'hA5C2, 16'hFFFF);
      rd(2'h2, 12'h007, 8'hFF, 2'b00, 16'h7777, 16'hFFFF);
      // Queue filled until refused, then drained in order
      saw_full = 1'b0;
      for (int i = 0; i < 40; i++) begin
         if (req_ready === 1'b0) begin
            saw_full = 1'b1;
         end
         push(1'b1, 2'h3, 12'h001, 8'(i), 2'b00, 16'hB000 + 16'(i));
      end
      check({15'h0000, saw_full}, 16'h0001, "queue refused");
      rd(2'h3, 12'h001, 8'h00, 2'b00, 16'hB000, 16'hFFFF);
      rd(2'h3, 12'h001, 8'h27, 2'b00, 16'hB027, 16'hFFFF);
      // Clock gating enters suspend or power-down, then returns to run
      sleep_req = 1'b1;
      wait_for(i_sdram_if.clock_gate, 1'b0);
      @(negedge clk);
      check({15'h0000, power_mode inside {sdram_pkg::PWR_SUSPEND,
         sdram_pkg::PWR_DOWN}}, 16'h0001, "gated mode");
      sleep_req = 1'b0;
      wait_for(i_sdram_if.clock_gate, 1'b1);
      repeat (2) @(negedge clk);
      check({12'h000, power_mode}, 16'h0001, "back to run");
      // A request offered while the enable is low must be lost
      clk_en = 1'b0;
      push(1'b1, 2'h0, 12'h005, 8'h12, 2'b00, 16'h0BAD);
      req_valid = 1'b0;
      clk_en = 1'b1;
      rd(2'h0, 12'h005, 8'h12, 2'b00, 16'hA5C0, 16'hFFFF);
      do_reset();
      end_of_test();
   end
endmodule // sdram_pin_command_interface_tb
